// [hdl/clkgen_pkg.sv]
// Purpose: shared constants and types of the programmable clock generator control
// Assumes: 200 MHz system clock
// Notes:   configuration words are 9 bits wide

package clkgen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration words
  localparam int unsigned WORD_W        = 9;
  localparam int unsigned NV_WORDS      = 2;
  localparam int unsigned NV_ADDR_W     = 1;
  localparam logic [0:0]  ADDR_MODE     = 1'h0;
  localparam logic [0:0]  ADDR_DIV      = 1'h1;
  localparam int unsigned SHIFT_W       = 18;

  // mode word field positions, lsb upward
  localparam int unsigned BIT_REF_EXT   = 0;
  localparam int unsigned BIT_DIV_BYP   = 1;
  localparam int unsigned BIT_PRE_BYP   = 2;
  localparam int unsigned BIT_PRE_HALF  = 3;
  localparam int unsigned BIT_PIN_FUNC  = 4;
  localparam int unsigned BIT_REF_DIS   = 5;

  // factory setting: internal oscillator, no prescale, divide by two
  localparam logic [8:0]  MODE_RESET    = 9'h014;
  localparam logic [8:0]  DIV_RESET     = 9'h000;
  localparam logic [9:0]  DIV_OFFSET    = 10'h002;

  // prescaler half periods counted in reference rising edges
  localparam logic [1:0]  PRE_HALF_DIV4 = 2'h2;
  localparam logic [1:0]  PRE_HALF_DIV2 = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned WAKE_TIME_NS  = 10000;
  localparam int unsigned WAKE_CYCLES   = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_W        = 12;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic       ref_dis;
    logic       pin_func;
    logic       pre_half;
    logic       pre_byp;
    logic       div_byp;
    logic       ref_ext;
    logic [8:0] n;
  } config_s;

  typedef enum logic [2:0] {
    ST_RUN       = 3'h0,
    ST_DRAIN_DIV = 3'h1,
    ST_DRAIN_REF = 3'h3,
    ST_OFF       = 3'h2,
    ST_WAKE      = 3'h6
  } power_state_e;

endpackage

// [hdl/sync2.sv]
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: inputs are quasi-static against the clock
// Notes:   the first stage feeds only the second stage

`timescale 1ns/1ps

module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end else begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule

// [hdl/nv_config_mem.sv]
// Purpose: nonvolatile store of the two configuration words
// Assumes: contents survive reset; only the write port changes them
// Notes:   read data come out of a register

`timescale 1ns/1ps

module nv_config_mem #(
  parameter int unsigned         WIDTH  = clkgen_pkg::WORD_W,
  parameter logic [WIDTH-1:0]    INIT0  = clkgen_pkg::MODE_RESET,
  parameter logic [WIDTH-1:0]    INIT1  = clkgen_pkg::DIV_RESET
) (
  // clock
  input  wire logic             clock_i,
  // write port
  input  wire logic             wr_en_i,
  input  wire logic [0:0]       wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input  wire logic [0:0]       rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  // delivered contents; no reset so the words outlive a power cycle
  logic [WIDTH-1:0] cell_reg [clkgen_pkg::NV_WORDS] = '{INIT0, INIT1};

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      cell_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= cell_reg[rd_addr_i];
  end

endmodule

// [hdl/programmable_clock_gen_control.sv]
// Purpose: control of a programmable clock generator with prescaler, divider and gating
// Assumes: reference clocks arrive as pin levels well below the 200 MHz system clock
// Notes:   pin outputs are registered levels; a pin output is released by its enable

`timescale 1ns/1ps

module programmable_clock_gen_control #(
  parameter int unsigned WAKE_COUNT = clkgen_pkg::WAKE_CYCLES
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // reference sources
  input  wire logic int_osc_i,
  input  wire logic ext_clk_i,
  output logic      osc_enable_o,
  // control pins
  input  wire logic output_enable_i,
  input  wire logic powerdown_or_refselect_pin_i,
  input  wire logic prog_mode_i,
  input  wire logic prog_sclk_i,
  input  wire logic prog_write_i,
  input  wire logic prog_readback_i,
  // dual-purpose pin
  input  wire logic io_in_i,
  output logic      io_out_o,
  output logic      io_oe_o,
  // reference clock output
  output logic      reference_clock_out_o,
  output logic      reference_clock_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [8:0] pins_sync;
  logic       osc_s, ext_s, oe_s, dual_s, strap_s, sclk_s, write_s, rdbk_s, io_s;

  sync2 #(.WIDTH(9)) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({int_osc_i, ext_clk_i, output_enable_i, powerdown_or_refselect_pin_i,
                prog_mode_i, prog_sclk_i, prog_write_i, prog_readback_i, io_in_i}),
    .sync_o   (pins_sync)
  );

  assign {osc_s, ext_s, oe_s, dual_s, strap_s, sclk_s, write_s, rdbk_s, io_s} = pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // power-up: strap capture and configuration load
  logic [1:0]           strap_wait_reg;
  logic                 strap_done_reg;
  logic                 prog_reg;
  logic [1:0]           load_reg;
  logic                 load_done_reg;
  clkgen_pkg::config_s  cfg_reg;
  logic [8:0]           nv_rd_data;
  logic [0:0]           nv_rd_addr;
  logic                 nv_wr_en;
  logic [0:0]           nv_wr_addr;
  logic [8:0]           nv_wr_data;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      prog_reg       <= 1'b0;
    end else if (!strap_done_reg) begin
      // the synchroniser leaves reset empty; take the strap once it has filled
      if (strap_wait_reg == 2'h2) begin
        strap_done_reg <= 1'b1;
        prog_reg       <= strap_s;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  // words are fetched once per power-up; later writes wait for the next one
  assign nv_rd_addr = load_reg[0] ? clkgen_pkg::ADDR_DIV : clkgen_pkg::ADDR_MODE;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_reg      <= 2'h0;
      load_done_reg <= 1'b0;
      cfg_reg       <= '0;
    end else if (strap_done_reg && !load_done_reg) begin
      load_reg <= load_reg + 2'h1;
      if (load_reg == 2'h1) begin
        cfg_reg[14:9] <= nv_rd_data[5:0];
      end
      if (load_reg == 2'h2) begin
        cfg_reg.n     <= nv_rd_data;
        load_done_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming port
  logic [17:0] shift_reg;
  logic [1:0]  wr_step_reg;
  logic        sclk_prev_reg, write_prev_reg;
  wire         sclk_rise  = sclk_s & ~sclk_prev_reg;
  wire         write_rise = write_s & ~write_prev_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_reg      <= '0;
      wr_step_reg    <= 2'h0;
      sclk_prev_reg  <= 1'b0;
      write_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg  <= sclk_s;
      write_prev_reg <= write_s;
      if (prog_reg && sclk_rise) begin
        // data bit passes the same two stages as its serial clock
        shift_reg <= {shift_reg[16:0], io_s};
      end
      if (prog_reg && write_rise && wr_step_reg == 2'h0) begin
        wr_step_reg <= 2'h1;
      end else if (wr_step_reg != 2'h0) begin
        wr_step_reg <= (wr_step_reg == 2'h2) ? 2'h0 : 2'h2;
      end
    end
  end

  // upper nine bits go to the mode word, lower nine to the divider
  assign nv_wr_en   = (wr_step_reg != 2'h0);
  assign nv_wr_addr = (wr_step_reg == 2'h1) ? clkgen_pkg::ADDR_MODE : clkgen_pkg::ADDR_DIV;
  assign nv_wr_data = (wr_step_reg == 2'h1) ? shift_reg[17:9] : shift_reg[8:0];

  nv_config_mem u_nv (
    .clock_i   (clock_i),
    .wr_en_i   (nv_wr_en),
    .wr_addr_i (nv_wr_addr),
    .wr_data_i (nv_wr_data),
    .rd_addr_i (nv_rd_addr),
    .rd_data_o (nv_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power sequencer
  clkgen_pkg::power_state_e state_reg, state_next;
  logic [clkgen_pkg::WAKE_W-1:0] wake_reg;
  logic        run_reg;
  logic        ref_gate_reg;
  logic        div_pin_reg;
  logic        ref_pin_reg;
  wire         active   = load_done_reg & ~prog_reg;
  wire         pdn_req  = cfg_reg.pin_func & ~dual_s;
  wire         wake_end = (wake_reg == clkgen_pkg::WAKE_W'(WAKE_COUNT - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      clkgen_pkg::ST_RUN:       if (pdn_req) state_next = clkgen_pkg::ST_DRAIN_DIV;
      clkgen_pkg::ST_DRAIN_DIV: if (!run_reg) state_next = clkgen_pkg::ST_DRAIN_REF;
      clkgen_pkg::ST_DRAIN_REF: if (!ref_gate_reg) state_next = clkgen_pkg::ST_OFF;
      clkgen_pkg::ST_OFF:       if (!pdn_req) state_next = clkgen_pkg::ST_WAKE;
      clkgen_pkg::ST_WAKE:      if (wake_end) state_next = clkgen_pkg::ST_RUN;
      default:                  state_next = clkgen_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= clkgen_pkg::ST_RUN;
      wake_reg  <= '0;
    end else begin
      state_reg <= active ? state_next : clkgen_pkg::ST_RUN;
      wake_reg  <= (state_reg == clkgen_pkg::ST_WAKE) ? wake_reg + clkgen_pkg::WAKE_W'(1) : '0;
    end
  end

  // a slow restart is the price of powering the oscillator fully down
  wire osc_on = (state_reg != clkgen_pkg::ST_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // reference selection, switched only while both sides are low
  logic sel_ext_reg, muted_reg, ref_lvl_reg, ref_prev_reg;
  wire  want_ext = cfg_reg.pin_func ? cfg_reg.ref_ext : ~dual_s;
  wire  cur_lvl  = sel_ext_reg ? ext_s : osc_s;
  wire  new_lvl  = want_ext ? ext_s : osc_s;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_ext_reg  <= 1'b0;
      muted_reg    <= 1'b0;
      ref_lvl_reg  <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      if (!muted_reg && want_ext != sel_ext_reg && !cur_lvl) begin
        muted_reg <= 1'b1;
      end else if (muted_reg && !new_lvl) begin
        sel_ext_reg <= want_ext;
        muted_reg   <= 1'b0;
      end
      ref_lvl_reg  <= osc_on & ~muted_reg & cur_lvl;
      ref_prev_reg <= ref_lvl_reg;
    end
  end

  wire ref_rise = ref_lvl_reg & ~ref_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, applied only to the internal reference
  logic [1:0] pre_cnt_reg;
  logic       mclk_reg, mclk_prev_reg;
  wire        pre_use  = ~sel_ext_reg & ~cfg_reg.pre_byp;
  wire  [1:0] pre_half = cfg_reg.pre_half ? clkgen_pkg::PRE_HALF_DIV2 : clkgen_pkg::PRE_HALF_DIV4;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt_reg   <= 2'h0;
      mclk_reg      <= 1'b0;
      mclk_prev_reg <= 1'b0;
    end else begin
      mclk_prev_reg <= mclk_reg;
      if (!pre_use) begin
        pre_cnt_reg <= 2'h0;
        mclk_reg    <= ref_lvl_reg;
      end else if (ref_rise) begin
        pre_cnt_reg <= (pre_cnt_reg == pre_half - 2'h1) ? 2'h0 : pre_cnt_reg + 2'h1;
        if (pre_cnt_reg == pre_half - 2'h1) begin
          mclk_reg <= ~mclk_reg;
        end
      end
    end
  end

  wire mclk_rise = mclk_reg & ~mclk_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // programmable divider with synchronous gating
  logic [9:0] div_cnt_reg;
  logic       div_lvl_reg, oe_mclk_reg;
  wire  [9:0] divisor  = {1'b0, cfg_reg.n} + clkgen_pkg::DIV_OFFSET;
  wire  [9:0] high_len = (divisor + 10'h001) >> 1;
  wire        out_lvl  = cfg_reg.div_byp ? (mclk_reg & run_reg) : div_lvl_reg;
  wire        stop_req = ~oe_mclk_reg | (state_reg != clkgen_pkg::ST_RUN);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_mclk_reg <= 1'b0;
      run_reg     <= 1'b0;
      div_cnt_reg <= '0;
      div_lvl_reg <= 1'b0;
    end else begin
      if (mclk_rise) begin
        oe_mclk_reg <= oe_s;
      end
      // start on the rise that sees enable, so unless the divider is bypassed the first edge follows one master period later
      if (mclk_rise && oe_s && state_reg == clkgen_pkg::ST_RUN) begin
        run_reg <= 1'b1;
      end else if (stop_req && !out_lvl) begin
        // a low output stops at once, a high one waits for its falling edge
        run_reg <= 1'b0;
      end
      if (!run_reg) begin
        div_cnt_reg <= '0;
        div_lvl_reg <= 1'b0;
      end else if (mclk_rise) begin
        div_cnt_reg <= (div_cnt_reg == divisor - 10'h001) ? 10'h000 : div_cnt_reg + 10'h001;
        div_lvl_reg <= (div_cnt_reg < high_len);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference output gate, closed only while the reference is low
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_gate_reg <= 1'b0;
    end else if (cfg_reg.ref_dis || state_reg == clkgen_pkg::ST_DRAIN_REF || !osc_on) begin
      if (!ref_lvl_reg) begin
        ref_gate_reg <= 1'b0;
      end
    end else if (active && state_reg != clkgen_pkg::ST_WAKE && !ref_lvl_reg) begin
      ref_gate_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_pin_reg <= 1'b0;
      ref_pin_reg <= 1'b0;
    end else begin
      div_pin_reg <= prog_reg ? shift_reg[17] : out_lvl;
      ref_pin_reg <= ref_gate_reg & ref_lvl_reg;
    end
  end

  assign io_out_o              = div_pin_reg;
  assign io_oe_o               = prog_reg ? rdbk_s : (active & osc_on);
  assign reference_clock_out_o = ref_pin_reg;
  assign reference_clock_oe_o  = active & osc_on & ~cfg_reg.ref_dis;
  assign osc_enable_o          = osc_on;

endmodule

// [sim/programmable_clock_gen_control_asserts.sv]
// Purpose: port checker of the clock generator control
// Assumes: reference clocks far slower than clock_i
// Notes:   saturating counters stand in for long waits
`timescale 1ns/1ps
module programmable_clock_gen_control_asserts #(
  parameter int unsigned WAKE_COUNT = clkgen_pkg::WAKE_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic int_osc_i,
  input wire logic ext_clk_i,
  input wire logic osc_enable_o,
  input wire logic output_enable_i,
  input wire logic powerdown_or_refselect_pin_i,
  input wire logic prog_mode_i,
  input wire logic prog_sclk_i,
  input wire logic prog_write_i,
  input wire logic prog_readback_i,
  input wire logic io_in_i,
  input wire logic io_out_o,
  input wire logic io_oe_o,
  input wire logic reference_clock_out_o,
  input wire logic reference_clock_oe_o
);
  // limits cover two slowest master periods plus synchroniser latency
  localparam int GATE_LIMIT = 200;
  localparam int REF_LIMIT  = 200;
  logic [7:0] gate_cnt;
  logic [7:0] ref_cnt;
  logic       ref_prev;
  // settled operating cycles, so the drive check needs no long repetition
  logic [7:0] oper_cnt;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_cnt <= 8'h00;
      ref_cnt  <= 8'h00;
      ref_prev <= 1'b0;
      oper_cnt <= 8'h00;
    end else begin
      gate_cnt <= output_enable_i ? 8'h00 : (gate_cnt == 8'hFF ? gate_cnt : gate_cnt + 8'h01);
      ref_cnt  <= (reference_clock_out_o != ref_prev) ? 8'h00 : (ref_cnt == 8'hFF ? ref_cnt : ref_cnt + 8'h01);
      ref_prev <= reference_clock_out_o;
      oper_cnt <= (!prog_mode_i && osc_enable_o) ? (oper_cnt == 8'hFF ? oper_cnt : oper_cnt + 8'h01) : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  a_off_released: assert property (
    !osc_enable_o |-> !io_oe_o && !reference_clock_oe_o) else $error("output driven while oscillator off");
  a_off_order: assert property (
    $fell(osc_enable_o) |-> !$past(io_out_o) && !$past(reference_clock_out_o)) else $error("oscillator off before drain");
  a_off_needs_pin: assert property (
    $fell(osc_enable_o) |-> !$past(powerdown_or_refselect_pin_i, 2)) else $error("power-down without low pin");
  a_wake_on_pin: assert property (
    !osc_enable_o && powerdown_or_refselect_pin_i |-> ##[1:8] osc_enable_o) else $error("no wake on pin high");
  a_gate_rise_bound: assert property (
    $rose(io_out_o) |-> gate_cnt < GATE_LIMIT) else $error("divided pulse long after gating");
  a_gate_held_low: assert property (
    gate_cnt == 8'hFF |-> !io_out_o) else $error("gated output not low");
  a_prog_no_drive: assert property (
    (prog_mode_i && !prog_readback_i) [*4] |-> !io_oe_o) else $error("pin driven in programming mode");
  a_prog_ref_off: assert property (
    prog_mode_i [*4] |-> !reference_clock_oe_o) else $error("reference driven in programming mode");
  a_oper_drive: assert property (
    !prog_mode_i && osc_enable_o && oper_cnt >= 8'h0B |-> io_oe_o) else $error("pin not driven in operating mode");
  a_ref_toggles: assert property (
    reference_clock_oe_o && osc_enable_o |-> ref_cnt < REF_LIMIT) else $error("reference output stuck");
endmodule

bind programmable_clock_gen_control programmable_clock_gen_control_asserts #(.WAKE_COUNT(WAKE_COUNT)) checker_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .int_osc_i(int_osc_i), .ext_clk_i(ext_clk_i),
  .osc_enable_o(osc_enable_o), .output_enable_i(output_enable_i),
  .powerdown_or_refselect_pin_i(powerdown_or_refselect_pin_i), .prog_mode_i(prog_mode_i),
  .prog_sclk_i(prog_sclk_i), .prog_write_i(prog_write_i), .prog_readback_i(prog_readback_i),
  .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
  .reference_clock_out_o(reference_clock_out_o), .reference_clock_oe_o(reference_clock_oe_o));

// [sim/board_model.sv]
// Purpose: board side: reference sources and the dual-purpose pin wire
// Assumes: references are whole multiples of clock_i
// Notes:   a released pin shows the programmer's data while it drives, else the inverse of its last driven level
`timescale 1ns/1ps
module board_model #(
  parameter int unsigned INT_HALF = 8,
  parameter int unsigned EXT_HALF = 5
) (
  input  wire logic clock_i,
  input  wire logic osc_enable_i,
  input  wire logic io_out_i,
  input  wire logic io_oe_i,
  input  wire logic host_en_i,
  input  wire logic host_d_i,
  output logic      int_osc_o,
  output logic      ext_clk_o,
  output logic      io_wire_o
);
  logic [7:0] int_cnt = 8'h00;
  logic [7:0] ext_cnt = 8'h00;
  logic       last_q  = 1'b0;
  initial int_osc_o = 1'b0;
  initial ext_clk_o = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    if (io_oe_i) begin
      last_q <= io_out_i;
    end
    ext_cnt <= (ext_cnt == 8'(EXT_HALF - 1)) ? 8'h00 : ext_cnt + 8'h01;
    ext_clk_o <= (ext_cnt == 8'(EXT_HALF - 1)) ? !ext_clk_o : ext_clk_o;
    // oscillator stands still while powered down
    if (osc_enable_i) begin
      int_cnt <= (int_cnt == 8'(INT_HALF - 1)) ? 8'h00 : int_cnt + 8'h01;
      int_osc_o <= (int_cnt == 8'(INT_HALF - 1)) ? !int_osc_o : int_osc_o;
    end
  end
  // serial data only from the programmer while the device does not drive
  assign io_wire_o = io_oe_i ? io_out_i : (host_en_i ? host_d_i : !last_q);
endmodule

// [sim/programmable_clock_gen_control_tb_top.sv]
// Purpose: self-checking bench of the clock generator control
// Assumes: board_model supplies references, checker bound to the top
// Notes:   periods measured in clock_i cycles between divided rises
`timescale 1ns/1ps
module programmable_clock_gen_control_tb_top;
  localparam int unsigned WAKE = 4;
  localparam int unsigned IH   = 8;
  localparam int unsigned EH   = 5;
  localparam logic [8:0]  MODES [7] = '{9'h010, 9'h018, 9'h011, 9'h016, 9'h032, 9'h001, 9'h000};
  localparam logic [6:0]  PINS = 7'h3F;
  logic clock_i, resetn_i, int_osc, ext_clk, osc_en, oe, pin, prog, sclk, wr, rb;
  logic io_wire, io_out, io_oe, ref_out, ref_oe, host_en, host_d;
  int   err_count = 0;
  int   comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  board_model #(.INT_HALF(IH), .EXT_HALF(EH)) board (.clock_i(clock_i), .osc_enable_i(osc_en),
    .io_out_i(io_out), .io_oe_i(io_oe), .host_en_i(host_en), .host_d_i(host_d),
    .int_osc_o(int_osc), .ext_clk_o(ext_clk), .io_wire_o(io_wire));
  programmable_clock_gen_control #(.WAKE_COUNT(WAKE)) dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .int_osc_i(int_osc), .ext_clk_i(ext_clk), .osc_enable_o(osc_en), .output_enable_i(oe),
    .powerdown_or_refselect_pin_i(pin), .prog_mode_i(prog), .prog_sclk_i(sclk), .prog_write_i(wr),
    .prog_readback_i(rb), .io_in_i(io_wire), .io_out_o(io_out), .io_oe_o(io_oe),
    .reference_clock_out_o(ref_out), .reference_clock_oe_o(ref_oe));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // strap is set inside reset so it is steady while the synchroniser fills after release
  task automatic power_up(input logic p);
    resetn_i <= 1'b0;
    prog <= p;
    cyc(5);
    resetn_i <= 1'b1;
    cyc(20);
  endtask
  task automatic rise_wait(output int n);
    n = 0;
    while (io_out !== 1'b0 && n < 12000) begin
      cyc(1);
      n++;
    end
    while (io_out !== 1'b1 && n < 12000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic period(output int p);
    rise_wait(p);
    rise_wait(p);
  endtask
  task automatic program_words(input logic [17:0] w);
    for (int i = 17; i >= 0; i--) begin
      host_d <= w[i];
      cyc(4);
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
      cyc(4);
    end
    rb <= 1'b1;
    cyc(6);
    check({io_oe, io_out}, 2'b10);
    rb <= 1'b0;
    cyc(6);
    check(io_oe, 1'b0);
    wr <= 1'b1;
    cyc(4);
    wr <= 1'b0;
    cyc(10);
  endtask
  function automatic int exp_period(input logic [8:0] m, input logic [8:0] n, input logic p);
    logic ext;
    int   per;
    ext = m[4] ? m[0] : !p;
    per = ext ? 2 * EH : 2 * IH * (m[2] ? 1 : (m[3] ? 2 : 4));
    return per * (m[1] ? 1 : int'(n) + 2);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    finish_test();
  end
  initial begin
    int         per;
    int         n;
    int         tg;
    logic       rp;
    logic       hi;
    logic [8:0] nv;
    resetn_i = 1'b0;
    oe = 1'b1;
    pin = 1'b1;
    prog = 1'b0;
    sclk = 1'b0;
    wr = 1'b0;
    rb = 1'b0;
    host_en = 1'b0;
    host_d = 1'b0;
    void'($urandom(32'h77FD));
    cyc(1);
    power_up(1'b0);
    period(per);
    check(16'(per), 16'(exp_period(9'h014, 9'h000, 1'b1)));
    check({io_oe, ref_oe}, 2'b11);
    // long gate so the checker sees a saturated count
    oe <= 1'b0;
    cyc(300);
    tg = 0;
    hi = 1'b0;
    rp = ref_out;
    repeat (64) begin
      cyc(1);
      tg += int'(ref_out !== rp);
      rp = ref_out;
      hi |= io_out;
    end
    check({hi, 1'b0}, {1'b0, tg == 0});
    oe <= 1'b1;
    rise_wait(n);
    check(n <= 4 * IH + 8, 1'b1);
    pin <= 1'b0;
    n = 0;
    while (osc_en !== 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    cyc(2);
    check({io_oe, ref_oe, osc_en}, 3'h0);
    pin <= 1'b1;
    cyc(WAKE + 20);
    period(per);
    check(16'(per), 16'(2 * 2 * IH));
    for (int i = 0; i < 7; i++) begin
      nv = (i == 2) ? 9'h1FF : 9'($urandom_range(5, 0));
      host_en <= 1'b1;
      power_up(1'b1);
      program_words({MODES[i], nv});
      host_en <= 1'b0;
      pin <= PINS[i];
      power_up(1'b0);
      period(per);
      check(16'(per), 16'(exp_period(MODES[i], nv, PINS[i])));
      check(ref_oe, !MODES[i][5]);
    end
    finish_test();
  end
endmodule
